/* File: shared/txd_pkg.sv */
package txd_pkg;
  // ==========================================================
  // Descriptor word 1 field positions and widths
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 20;
  localparam int TYPE_LSB = 20;
  localparam int TYPE_W = 4;
  localparam int CMD_LSB = 24;
  localparam int CMD_W = 8;
  localparam int STAT_LSB = 32;
  localparam int STAT_W = 4;
  localparam int OPT_LSB = 40;
  localparam int OPT_W = 8;
  localparam int TAG_LSB = 48;
  localparam int TAG_W = 16;
  // ==========================================================
  // Command byte bit positions
  localparam int CMD_DELAY_BIT = 7;
  localparam int CMD_VLAN_BIT = 6;
  localparam int CMD_EXT_BIT = 5;
  localparam int CMD_SENT_BIT = 4;
  localparam int CMD_REPORT_BIT = 3;
  localparam int CMD_SEG_BIT = 2;
  localparam int CMD_FCS_BIT = 1;
  localparam int CMD_END_BIT = 0;
  // ==========================================================
  // Encodings and reset values
  localparam logic [3:0] TYPE_DATA = 4'h1;
  localparam logic [3:0] STAT_DONE = 4'h1;
  localparam logic [63:0] WORD_RST = 64'h0;
  localparam logic [15:0] DELAY_RST = 16'h0;
  // ==========================================================
  // Timing: one delay unit, and the clock period
  localparam int DELAY_UNIT_NS = 1024;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS / CLK_PERIOD_NS < 1) ? 1
                                  : DELAY_UNIT_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  // ==========================================================
  // Decoder states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FETCH = 3'h2,
    ST_WB = 3'h4
  } dec_state_e;
endpackage : txd_pkg

/* File: design/irq_delay_timer.sv */
module irq_delay_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Requests from the decoder
  input wire logic load,
  input wire logic fire_now,
  input wire logic [15:0] delay_value_field,
  // Interrupt pulse
  output logic irq_q
);
  // ==========================================================
  // Delay unit divider
  logic [txd_pkg::DIV_W-1:0] div_q;
  logic tick;
  logic [15:0] count_q;
  logic active_q;

  assign tick = (div_q == txd_pkg::DIV_W'(txd_pkg::DELAY_UNIT_CYC - 1));

  always_ff @(posedge ref_clk)
  begin
    if (rst || tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // ==========================================================
  // Countdown, reloaded even while it runs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      count_q <= txd_pkg::DELAY_RST;
      active_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= 1'b0;
      if (fire_now)
      begin
        active_q <= 1'b0;
        irq_q <= 1'b1;
      end
      else if (load)
      begin
        count_q <= delay_value_field;
        active_q <= 1'b1;
      end
      else if (active_q && (count_q == 16'h0))
      begin
        active_q <= 1'b0;
        irq_q <= 1'b1;
      end
      else if (active_q && tick)
        count_q <= count_q - 16'h1;
    end
  end

  reload_count_a: assert property (@(posedge ref_clk) disable iff (rst)
    load && !fire_now |=> active_q && count_q == $past(delay_value_field))
    else $error("countdown not reloaded from delay value");
  fire_now_a: assert property (@(posedge ref_clk) disable iff (rst)
    fire_now |=> irq_q && !active_q)
    else $error("immediate interrupt missing");
endmodule : irq_delay_timer

/* File: design/tx_offload_data_descriptor_decode.sv */
// Notes on behaviour
// - Only descriptors with the extension flag (bit 29) set and type 0001b are decoded as data.
// - Word 0 is the 64-bit host address of the data buffer for one piece of the packet.
// - Bits 19..0 of word 1 give the byte count of that buffer.
// - The option byte at bits 47..40 counts only on a packet's first descriptor.
// - The 16-bit tag at bits 63..48 counts only on the end-of-packet descriptor.
// - The command byte at bits 31..24 decodes, high to low, delay, vlan, ext, sent, report, seg, fcs, end.
// - A write-back with delay and report reloads the countdown; report alone interrupts at once.
// - With report set, status is reported once the buffer is fetched into the packet buffer.
// - Status goes back with the done bit set only for descriptors whose report bit is set.
// - The vlan insert flag counts only on the end-of-packet descriptor.
module tx_offload_data_descriptor_decode (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Descriptor input
  input wire logic desc_valid,
  input wire logic [63:0] desc_word0,
  input wire logic [63:0] desc_word1,
  output logic desc_ready_q,
  output logic bad_desc_q,
  // Buffer fetch request and completion
  output logic fetch_req_q,
  output logic [63:0] fetch_addr_q,
  output logic [19:0] fetch_len_q,
  input wire logic fetch_done,
  // Per-descriptor command flags
  output logic segmentation_enable_flag_q,
  output logic insert_fcs_flag_q,
  output logic report_sent_flag_q,
  // Per-packet results
  output logic packet_done_q,
  output logic [7:0] packet_option_byte_q,
  output logic [15:0] vlan_tag_q,
  output logic vlan_insert_flag_q,
  // Status write-back
  output logic wb_valid_q,
  output logic [63:0] wb_word1_q,
  // Interrupt delay
  input wire logic [15:0] delay_value_field,
  output logic tx_irq_q
);
  // ==========================================================
  // Field extraction
  txd_pkg::dec_state_e state_q;
  logic [63:0] word1_q;
  logic [7:0] command_byte;
  logic [7:0] in_command;
  logic [3:0] in_type;
  logic is_data;
  logic first_q;
  logic accept;
  logic finish;
  logic rep;
  logic last;

  assign in_command = desc_word1[txd_pkg::CMD_LSB +: txd_pkg::CMD_W];
  assign in_type = desc_word1[txd_pkg::TYPE_LSB +: txd_pkg::TYPE_W];
  assign is_data = in_command[txd_pkg::CMD_EXT_BIT]
                   && (in_type == txd_pkg::TYPE_DATA);
  assign command_byte = word1_q[txd_pkg::CMD_LSB +: txd_pkg::CMD_W];
  assign rep = command_byte[txd_pkg::CMD_REPORT_BIT];
  assign last = command_byte[txd_pkg::CMD_END_BIT];
  assign accept = desc_valid && desc_ready_q;
  assign finish = (state_q == txd_pkg::ST_FETCH) && fetch_done;

  // ==========================================================
  // Sequencing
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_q <= txd_pkg::ST_IDLE;
    else
      unique case (state_q)
        txd_pkg::ST_IDLE:
          if (accept && is_data)
            state_q <= txd_pkg::ST_FETCH;
        txd_pkg::ST_FETCH:
          if (fetch_done)
            state_q <= txd_pkg::ST_WB;
        txd_pkg::ST_WB:
          state_q <= txd_pkg::ST_IDLE;
        default:
          state_q <= txd_pkg::ST_IDLE;
      endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      desc_ready_q <= 1'b0;
    else
      desc_ready_q <= (state_q == txd_pkg::ST_IDLE && !accept)
                      || state_q == txd_pkg::ST_WB
                      || (state_q == txd_pkg::ST_IDLE && accept && !is_data);
  end

  // ==========================================================
  // Capture and fetch request
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      word1_q <= txd_pkg::WORD_RST;
      fetch_addr_q <= txd_pkg::WORD_RST;
      fetch_len_q <= '0;
      fetch_req_q <= 1'b0;
      bad_desc_q <= 1'b0;
      segmentation_enable_flag_q <= 1'b0;
      insert_fcs_flag_q <= 1'b0;
      report_sent_flag_q <= 1'b0;
    end
    else
    begin
      fetch_req_q <= accept && is_data;
      bad_desc_q <= accept && !is_data;
      if (accept && is_data)
      begin
        word1_q <= desc_word1;
        fetch_addr_q <= desc_word0;
        fetch_len_q <= desc_word1[txd_pkg::LEN_LSB +: txd_pkg::LEN_W];
        segmentation_enable_flag_q <= in_command[txd_pkg::CMD_SEG_BIT];
        insert_fcs_flag_q <= in_command[txd_pkg::CMD_FCS_BIT];
        report_sent_flag_q <= in_command[txd_pkg::CMD_SENT_BIT];
      end
    end
  end

  // ==========================================================
  // Packet gathering
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      first_q <= 1'b1;
      packet_done_q <= 1'b0;
      packet_option_byte_q <= '0;
      vlan_tag_q <= '0;
      vlan_insert_flag_q <= 1'b0;
    end
    else
    begin
      packet_done_q <= finish && last;
      if (finish)
      begin
        first_q <= last;
        if (first_q)
          packet_option_byte_q <= word1_q[txd_pkg::OPT_LSB +: txd_pkg::OPT_W];
        if (last)
        begin
          vlan_tag_q <= word1_q[txd_pkg::TAG_LSB +: txd_pkg::TAG_W];
          vlan_insert_flag_q <= command_byte[txd_pkg::CMD_VLAN_BIT];
        end
      end
    end
  end

  // ==========================================================
  // Status write-back, only once the buffer sits in the packet buffer
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wb_valid_q <= 1'b0;
      wb_word1_q <= txd_pkg::WORD_RST;
    end
    else
    begin
      wb_valid_q <= finish && rep;
      if (finish && rep)
      begin
        wb_word1_q <= word1_q;
        wb_word1_q[txd_pkg::STAT_LSB +: txd_pkg::STAT_W] <= txd_pkg::STAT_DONE;
      end
    end
  end

  // ==========================================================
  // Interrupt timing follows each write-back
  irq_delay_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(finish && rep && command_byte[txd_pkg::CMD_DELAY_BIT]),
    .fire_now(finish && rep && !command_byte[txd_pkg::CMD_DELAY_BIT]),
    .delay_value_field(delay_value_field),
    .irq_q(tx_irq_q)
  );

  // ==========================================================
  // Checks
  sequence accept_data_s;
    desc_valid && desc_ready_q && is_data;
  endsequence
  sequence finish_s;
    state_q == txd_pkg::ST_FETCH && fetch_done;
  endsequence

  decode_reject_a: assert property (@(posedge ref_clk) disable iff (rst)
    desc_valid && desc_ready_q && !is_data |=> bad_desc_q && !fetch_req_q)
    else $error("non-data descriptor not rejected");
  fetch_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    accept_data_s |=> fetch_req_q && fetch_addr_q == $past(desc_word0))
    else $error("fetch address wrong");
  fetch_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    accept_data_s |=> fetch_len_q == $past(desc_word1[19:0]))
    else $error("fetch length wrong");
  later_option_a: assert property (@(posedge ref_clk) disable iff (rst)
    finish_s and !first_q |=> $stable(packet_option_byte_q))
    else $error("option byte taken from later descriptor");
  tag_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(vlan_tag_q) |-> packet_done_q)
    else $error("tag changed outside packet end");
  cmd_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
    accept_data_s |=> insert_fcs_flag_q == $past(desc_word1[25])
    && segmentation_enable_flag_q == $past(desc_word1[26]))
    else $error("command byte decoded wrongly");
  wb_report_a: assert property (@(posedge ref_clk) disable iff (rst)
    finish_s |=> wb_valid_q == $past(rep))
    else $error("write-back does not follow report bit");
  vlan_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(vlan_insert_flag_q) |-> packet_done_q)
    else $error("vlan flag changed outside packet end");
  packet_end_a: assert property (@(posedge ref_clk) disable iff (rst)
    packet_done_q |-> first_q && $past(last))
    else $error("packet ended without end bit");
  wb_status_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_valid_q |-> wb_word1_q[35:32] == 4'h1 ##1 !wb_valid_q)
    else $error("status nibble wrong");
endmodule : tx_offload_data_descriptor_decode

/* File: bench/host_mem_model.sv */
// ==========================================================
// Host memory side: answers each buffer fetch after lat cycles.
module host_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fetch handshake
  input wire logic fetch_req_q,
  input wire logic [3:0] lat,
  output logic fetch_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // A latency of one is the fastest answer; larger values model a slow bus.
  always @(posedge ref_clk)
  begin
    fetch_done <= 1'b0;
    if (rst)
      cnt_q <= 4'h0;
    else if (fetch_req_q)
      cnt_q <= lat;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    if (!rst && !fetch_req_q && cnt_q == 4'h1)
      fetch_done <= 1'b1;
  end
endmodule : host_mem_model

/* File: bench/tx_offload_data_descriptor_decode_tb_top.sv */
module tx_offload_data_descriptor_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] k; logic [63:0] v;} exp_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic desc_valid = 1'b0;
  logic [63:0] w0 = 64'h0;
  logic [63:0] w1 = 64'h0;
  logic [15:0] dly = 16'h0;
  logic [3:0] lat = 4'h1;
  logic fetch_done;
  logic desc_ready_q, bad_desc_q, fetch_req_q, seg_q, fcs_q, sent_q;
  logic packet_done_q, vlan_insert_flag_q, wb_valid_q, tx_irq_q;
  logic [63:0] fetch_addr_q, wb_word1_q;
  logic [19:0] fetch_len_q;
  logic [7:0] packet_option_byte_q, first_opt, cmd;
  logic [15:0] vlan_tag_q;
  logic in_pkt = 1'b0;
  integer seed = 32'hfb2a;
  int n_fail = 0;
  int checks_done = 0;
  exp_s exq[$];
  tx_offload_data_descriptor_decode u_tx_offload_data_descriptor_decode (
    .ref_clk(ref_clk), .rst(rst), .desc_valid(desc_valid),
    .desc_word0(w0), .desc_word1(w1), .desc_ready_q(desc_ready_q),
    .bad_desc_q(bad_desc_q), .fetch_req_q(fetch_req_q),
    .fetch_addr_q(fetch_addr_q), .fetch_len_q(fetch_len_q),
    .fetch_done(fetch_done), .segmentation_enable_flag_q(seg_q),
    .insert_fcs_flag_q(fcs_q), .report_sent_flag_q(sent_q),
    .packet_done_q(packet_done_q),
    .packet_option_byte_q(packet_option_byte_q), .vlan_tag_q(vlan_tag_q),
    .vlan_insert_flag_q(vlan_insert_flag_q), .wb_valid_q(wb_valid_q),
    .wb_word1_q(wb_word1_q), .delay_value_field(dly), .tx_irq_q(tx_irq_q));
  host_mem_model u_host_mem_model (.ref_clk(ref_clk), .rst(rst),
    .fetch_req_q(fetch_req_q), .lat(lat), .fetch_done(fetch_done));
  always #2 ref_clk = ~ref_clk;
  // ==========================================================
  // Scoreboard
  task automatic chk(input logic [2:0] k, input logic [63:0] v);
    exp_s e;
    checks_done++;
    if (exq.size() == 0)
    begin
      n_fail++;
      $display("Error %0t: unexpected event %0d", $time, k);
    end
    else
    begin
      e = exq.pop_front();
      if (e.k !== k || e.v !== v)
      begin
        n_fail++;
        $display("Error %0t: event %0d got %h want %h", $time, k, v, e.v);
      end
    end
  endtask : chk
  // Pulses stand a whole cycle, so the falling edge sees them settled.
  always @(negedge ref_clk)
  begin
    if (!rst && fetch_req_q === 1'b1)
    begin
      chk(3'h0, fetch_addr_q);
      chk(3'h1, {41'h0, fetch_len_q, seg_q, fcs_q, sent_q});
    end
    if (!rst && bad_desc_q === 1'b1)
      chk(3'h2, 64'h0);
    if (!rst && packet_done_q === 1'b1)
      chk(3'h3, {39'h0, packet_option_byte_q, vlan_tag_q,
                 vlan_insert_flag_q});
    if (!rst && wb_valid_q === 1'b1)
      chk(3'h4, wb_word1_q);
    if (!rst && tx_irq_q === 1'b1)
      chk(3'h5, 64'h0);
  end
  // ==========================================================
  // Descriptor driver: notes expectations, offers, waits for all events
  task automatic send(input logic [7:0] c, input logic [3:0] typ,
                      input logic [7:0] opt, input logic [15:0] tag);
    logic [63:0] a;
    logic [19:0] len;
    int n;
    a = {$random(seed), $random(seed)};
    // Small buffers: byte counts run from 64 to 1087.
    len = 20'h00040 + (20'($random(seed)) & 20'h003FF);
    w0 <= a;
    w1 <= {tag, opt, 4'h0, 4'h0, c, typ, len};
    if (!(c[5] && typ == 4'h1))
      exq.push_back('{3'h2, 64'h0});
    else
    begin
      exq.push_back('{3'h0, a});
      exq.push_back('{3'h1, {41'h0, len, c[2], c[1], c[4]}});
      if (!in_pkt)
        first_opt = opt;
      in_pkt = !c[0];
      if (c[0])
        exq.push_back('{3'h3, {39'h0, first_opt, tag, c[6]}});
      if (c[3])
      begin
        exq.push_back('{3'h4, {tag, opt, 4'h0, 4'h1, c, typ, len}});
        exq.push_back('{3'h5, 64'h0});
      end
    end
    n = 0;
    while (desc_ready_q !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    desc_valid <= 1'b1;
    @(negedge ref_clk);
    desc_valid <= 1'b0;
    n = 0;
    while (exq.size() != 0 && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 1000)
    begin
      n_fail++;
      $display("Error %0t: events missing", $time);
      exq.delete();
    end
  endtask : send
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial
  begin
    #200000;
    n_fail++;
    $display("Error %0t: watchdog expired", $time);
    results();
  end
  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    // Options from the first piece, tag and vlan flag from the last.
    send(8'h60, 4'h1, 8'hA5, 16'h1111);
    send(8'h2B, 4'h1, 8'h5A, 16'hBEEF);
    $display("test multi descriptor packet done");
    // Foreign formats in mid-packet are dropped and leave it intact.
    send(8'h24, 4'h1, 8'h3C, 16'h0000);
    send(8'h01, 4'h1, 8'hFF, 16'hFFFF);
    send(8'h21, 4'h2, 8'hFF, 16'hFFFF);
    send(8'h61, 4'h1, 8'h00, 16'h0ABC);
    $display("test dropped formats done");
    // Delayed interrupts at counts zero and one.
    dly <= 16'h0000;
    send(8'hA9, 4'h1, 8'h11, 16'h2222);
    dly <= 16'h0001;
    send(8'hA9, 4'h1, 8'h33, 16'h4444);
    $display("test delayed interrupt done");
    repeat (30)
    begin
      cmd = 8'($random(seed));
      if (cmd[7])
        cmd[3] = 1'b1;
      lat <= 4'h1 + 4'($random(seed) & 7);
      dly <= 16'($random(seed) & 1);
      send(cmd, ($random(seed) & 3) == 0 ? 4'($random(seed)) : 4'h1,
           8'($random(seed)), 16'($random(seed)));
    end
    $display("test random descriptors done");
    repeat (20) @(negedge ref_clk);
    results();
  end
endmodule : tx_offload_data_descriptor_decode_tb_top
